//--- design/cte_chan.sv
// cte_chan.sv: source selection and polarity for both edge channels
// assumes: sources already in the aclk domain
`timescale 1ns/1ps
`default_nettype none
`include "cte_map.svh"
module cte_chan (
  // carrier from the register file
  cte_chan_if.chan ch
);
  // ==========================================================
  // one copy per channel; the result is a level, not an edge
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      wire logic lvl;  // selected raw level
      // selector decode shared by both channels
      assign lvl = (ch.sel[c] == `CTE_SRC_PIN_ONE) ? ch.src[0] :
                   (ch.sel[c] == `CTE_SRC_PIN_TWO) ? ch.src[1] :
                   (ch.sel[c] == `CTE_SRC_CMP_ONE) ? ch.src[2] :
                   ch.src[3];
      // polarity 1 answers a high level, 0 a low level
      assign ch.hit[c] = ch.pol[c] ? lvl : ~lvl;
    end
  endgenerate
endmodule // cte_chan
`default_nettype wire

//--- design/cte_chan_if.sv
// cte_chan_if.sv: carrier between register file and channel logic
// assumes: one clock, all signals on aclk
`timescale 1ns/1ps
`default_nettype none
interface cte_chan_if;
  logic [1:0][1:0] sel;   // per-channel source selector
  logic [1:0]      pol;   // per-channel polarity, 1 = high level
  logic [3:0]      src;   // pin one, pin two, cmp one, cmp two
  logic [1:0]      hit;   // qualified level per channel
  modport cfg  (output sel, output pol, output src, input hit);
  modport chan (input sel, input pol, input src, output hit);
endinterface
`default_nettype wire

//--- design/cte_map.svh
// cte_map.svh: register offsets, field positions and reset values
// assumes: included by bare name from the design modules
`ifndef CTE_MAP_SVH
`define CTE_MAP_SVH

// ==========================================================
// register byte offsets on the axi4-lite bus
`define CTE_OFS_CUR_CTRL  8'h00
`define CTE_OFS_EDGE_LOW  8'h04
`define CTE_OFS_EDGE_HIGH 8'h08

// ==========================================================
// current_control_reg fields
`define CTE_RANGE_LSB 0
`define CTE_RANGE_MSB 1
`define CTE_TRIM_LSB  2
`define CTE_TRIM_MSB  7

// ==========================================================
// edge_control_low fields
`define CTE_C1_FLAG_BIT 0
`define CTE_C2_FLAG_BIT 1
`define CTE_C1_SEL_LSB  2
`define CTE_C1_SEL_MSB  3
`define CTE_C1_POL_BIT  4
`define CTE_C2_SEL_LSB  5
`define CTE_C2_SEL_MSB  6
`define CTE_C2_POL_BIT  7

// ==========================================================
// edge_control_high fields
`define CTE_SEQ_EN_BIT 2

// ==========================================================
// reset values
`define CTE_RST_CUR_CTRL  8'h00
`define CTE_RST_EDGE_LOW  8'h00
`define CTE_RST_EDGE_HIGH 8'h00

// ==========================================================
// channel source selector codes
`define CTE_SRC_PIN_ONE 2'h3
`define CTE_SRC_PIN_TWO 2'h2
`define CTE_SRC_CMP_ONE 2'h1
`define CTE_SRC_CMP_TWO 2'h0

`endif

//--- design/cte_pkg.sv
// cte_pkg.sv: shared types of the charge/time edge-control block
// assumes: constants live in cte_map.svh
package cte_pkg;
  // ==========================================================
  // axi4-lite response codes
  typedef enum logic [1:0] {
    CTE_RESP_OKAY   = 2'h0,
    CTE_RESP_SLVERR = 2'h2
  } cte_resp_t;

  // ==========================================================
  // read channel states
  typedef enum logic [0:0] {
    CTE_RD_IDLE = 1'h0,
    CTE_RD_RESP = 1'h1
  } cte_rd_state_t;
endpackage

//--- design/cte_sync.sv
// cte_sync.sv: two-flop synchroniser for pin inputs
// assumes: inputs are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module cte_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  // ==========================================================
  // per-bit two-stage chain; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;  // first stage, read by second only
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg    <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg    <= async_in[i];
          sync_out[i] <= meta_reg;
        end
      end
    end
  endgenerate
endmodule // cte_sync
`default_nettype wire

//--- design/cte_top.sv
// cte_top.sv: edge control and configuration of a charge/time unit
// assumes: axi4-lite master on aclk; edge pins asynchronous;
// compare triggers come from logic on aclk
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cte_map.svh"
module cte_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  // axi4-lite write response
  output var  cte_pkg::cte_resp_t  s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]         s_axi_rdata,
  output var  cte_pkg::cte_resp_t  s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // edge sources
  input  wire logic                edge_pin_one,
  input  wire logic                edge_pin_two,
  input  wire logic                cmp_trig_one,
  input  wire logic                cmp_trig_two,
  // analog-facing controls
  output var  logic [1:0]          current_range,
  output var  logic [5:0]          current_trim,
  output var  logic                cur_src_en,
  // event status mirrors
  output var  logic                chan1_event_flag,
  output var  logic                chan2_event_flag
);
  import cte_pkg::*;

  // ==========================================================
  // register state
  logic [7:0]    cur_ctrl_reg;    // range and trim
  logic [7:0]    edge_low_reg;    // selectors, polarity, flags
  logic [7:0]    edge_high_reg;   // sequence enable
  logic [7:0]    edge_low_next;   // next edge_control_low
  logic          flag1_next;      // next channel 1 flag
  logic          flag2_next;      // next channel 2 flag

  // write channel holding state
  logic              aw_hold_reg;   // address captured
  logic              w_hold_reg;    // data captured
  logic [ADDR_W-1:0] awaddr_reg;    // captured address
  logic [7:0]        wdata_reg;     // captured low byte
  logic              wlane_reg;     // byte lane 0 enabled
  logic              aw_hold_next;  // next address hold
  logic              w_hold_next;   // next data hold
  logic              bvalid_next;   // next response valid

  // read channel state
  cte_rd_state_t     rd_state_reg;  // idle or answering
  cte_rd_state_t     rd_state_next; // next read state

  // ==========================================================
  // pin synchronisers; compare triggers are already on aclk
  logic [1:0] pins_sync;  // synchronised edge pins

  cte_sync #(
    .W (2)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({edge_pin_two, edge_pin_one}),
    .sync_out (pins_sync)
  );

  // ==========================================================
  // channel logic over the carrier
  cte_chan_if chan_bus ();

  assign chan_bus.sel[0] =
    edge_low_reg[`CTE_C1_SEL_MSB:`CTE_C1_SEL_LSB];
  assign chan_bus.sel[1] =
    edge_low_reg[`CTE_C2_SEL_MSB:`CTE_C2_SEL_LSB];
  assign chan_bus.pol[0] = edge_low_reg[`CTE_C1_POL_BIT];
  assign chan_bus.pol[1] = edge_low_reg[`CTE_C2_POL_BIT];
  assign chan_bus.src    = {cmp_trig_two, cmp_trig_one, pins_sync};

  cte_chan u_chan (
    .ch (chan_bus.chan)
  );

  // ==========================================================
  // write channel handshakes
  wire logic aw_take;   // address taken this edge
  wire logic w_take;    // data taken this edge
  wire logic wr_fire;   // both halves held, perform write
  wire logic b_done;    // response accepted

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign b_done  = s_axi_bvalid & s_axi_bready;

  // ==========================================================
  // write address decode
  wire logic wr_cur;   // write to current_control_reg
  wire logic wr_low;   // write to edge_control_low
  wire logic wr_high;  // write to edge_control_high
  wire logic wr_hit;   // mapped address

  assign wr_cur  = wr_fire & wlane_reg &
                   (awaddr_reg == ADDR_W'(`CTE_OFS_CUR_CTRL));
  assign wr_low  = wr_fire & wlane_reg &
                   (awaddr_reg == ADDR_W'(`CTE_OFS_EDGE_LOW));
  assign wr_high = wr_fire & wlane_reg &
                   (awaddr_reg == ADDR_W'(`CTE_OFS_EDGE_HIGH));
  assign wr_hit  = (awaddr_reg == ADDR_W'(`CTE_OFS_CUR_CTRL)) |
                   (awaddr_reg == ADDR_W'(`CTE_OFS_EDGE_LOW)) |
                   (awaddr_reg == ADDR_W'(`CTE_OFS_EDGE_HIGH));

  // ==========================================================
  // write channel next state: holds clear once the write fires
  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    bvalid_next  = s_axi_bvalid;
    if (wr_fire) begin
      // both halves consumed, answer next cycle
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
    end else begin
      if (aw_take) begin
        aw_hold_next = 1'b1;
      end
      if (w_take) begin
        w_hold_next = 1'b1;
      end
      if (b_done) begin
        bvalid_next = 1'b0;
      end
    end
  end

  // ==========================================================
  // write channel flops; ready drops while a half is held so a
  // second write cannot overrun the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CTE_RESP_OKAY;
    end else begin
      aw_hold_reg   <= aw_hold_next;
      w_hold_reg    <= w_hold_next;
      s_axi_awready <= ~aw_hold_next & ~bvalid_next;
      s_axi_wready  <= ~w_hold_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (wr_fire) begin
        // unmapped offsets answer with a slave error
        s_axi_bresp <= wr_hit ? CTE_RESP_OKAY : CTE_RESP_SLVERR;
      end
    end
  end

  // captured payload; no reset needed, only read under hold
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      awaddr_reg <= s_axi_awaddr;
    end
    if (w_take) begin
      wdata_reg <= s_axi_wdata[7:0];
      wlane_reg <= s_axi_wstrb[0];
    end
  end

  // ==========================================================
  // channel qualification
  wire logic ch1_resp;  // channel 1 level present
  wire logic ch2_resp;  // channel 2 accepted
  wire logic seq_en;    // sequence mode

  assign seq_en   = edge_high_reg[`CTE_SEQ_EN_BIT];
  assign ch1_resp = chan_bus.hit[0];
  // in sequence mode, channel 2 waits for a recorded channel 1 event
  assign ch2_resp = chan_bus.hit[1] &
                    (~seq_en | edge_low_reg[`CTE_C1_FLAG_BIT]);

  // ==========================================================
  // flag next values: a hardware set wins over a software clear
  // in the same cycle, so no event is lost
  always_comb begin
    flag1_next = edge_low_reg[`CTE_C1_FLAG_BIT];
    flag2_next = edge_low_reg[`CTE_C2_FLAG_BIT];
    if (wr_low) begin
      flag1_next = wdata_reg[`CTE_C1_FLAG_BIT];
      flag2_next = wdata_reg[`CTE_C2_FLAG_BIT];
    end
    // level checked every cycle, so a fresh config that already
    // matches the input sets the flag on the next edge
    flag1_next = flag1_next | ch1_resp;
    flag2_next = flag2_next | ch2_resp;
  end

  // ==========================================================
  // edge_control_low next value
  always_comb begin
    edge_low_next = edge_low_reg;
    if (wr_low) begin
      edge_low_next = wdata_reg;
    end
    edge_low_next[`CTE_C1_FLAG_BIT] = flag1_next;
    edge_low_next[`CTE_C2_FLAG_BIT] = flag2_next;
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ctrl_reg  <= `CTE_RST_CUR_CTRL;
      edge_low_reg  <= `CTE_RST_EDGE_LOW;
      edge_high_reg <= `CTE_RST_EDGE_HIGH;
    end else begin
      if (wr_cur) begin
        cur_ctrl_reg <= wdata_reg;
      end
      if (wr_high) begin
        // only the sequence bit is kept, the rest read zero
        edge_high_reg <= wdata_reg &
                         (8'h01 << `CTE_SEQ_EN_BIT);
      end
      edge_low_reg <= edge_low_next;
    end
  end

  // ==========================================================
  // current source gate: flag rises mark the two events; a
  // steady channel 1 level does not re-open after channel 2
  wire logic ev1_rise;  // channel 1 flag newly set
  wire logic ev2_rise;  // channel 2 flag newly set

  assign ev1_rise = flag1_next & ~edge_low_reg[`CTE_C1_FLAG_BIT];
  assign ev2_rise = flag2_next & ~edge_low_reg[`CTE_C2_FLAG_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_src_en <= 1'b0;
    end else if (ev2_rise) begin
      // stop wins: charging interval ends at channel 2
      cur_src_en <= 1'b0;
    end else if (ev1_rise) begin
      cur_src_en <= 1'b1;
    end
  end

  // ==========================================================
  // analog controls and status mirrors, all from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_range    <= 2'h0;
      current_trim     <= 6'h00;
      chan1_event_flag <= 1'b0;
      chan2_event_flag <= 1'b0;
    end else begin
      current_range <=
        cur_ctrl_reg[`CTE_RANGE_MSB:`CTE_RANGE_LSB];
      current_trim <=
        cur_ctrl_reg[`CTE_TRIM_MSB:`CTE_TRIM_LSB];
      chan1_event_flag <= edge_low_reg[`CTE_C1_FLAG_BIT];
      chan2_event_flag <= edge_low_reg[`CTE_C2_FLAG_BIT];
    end
  end

  // ==========================================================
  // read address decode
  wire logic        rd_take;  // read address taken
  wire logic        rd_hit;   // mapped read address
  wire logic [7:0]  rd_byte;  // selected register

  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_hit  = (s_axi_araddr == ADDR_W'(`CTE_OFS_CUR_CTRL)) |
                   (s_axi_araddr == ADDR_W'(`CTE_OFS_EDGE_LOW)) |
                   (s_axi_araddr == ADDR_W'(`CTE_OFS_EDGE_HIGH));
  assign rd_byte =
    (s_axi_araddr == ADDR_W'(`CTE_OFS_CUR_CTRL))  ? cur_ctrl_reg :
    (s_axi_araddr == ADDR_W'(`CTE_OFS_EDGE_LOW))  ? edge_low_reg :
    (s_axi_araddr == ADDR_W'(`CTE_OFS_EDGE_HIGH)) ? edge_high_reg :
    8'h00;

  // ==========================================================
  // read state machine: one read under way at a time
  always_comb begin
    case (rd_state_reg)
      CTE_RD_IDLE: begin
        rd_state_next = rd_take ? CTE_RD_RESP : CTE_RD_IDLE;
      end
      CTE_RD_RESP: begin
        rd_state_next = s_axi_rready ? CTE_RD_IDLE : CTE_RD_RESP;
      end
      default: begin
        rd_state_next = CTE_RD_IDLE;
      end
    endcase
  end

  // read channel flops; data is a snapshot at the address edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg  <= CTE_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CTE_RESP_OKAY;
    end else begin
      rd_state_reg  <= rd_state_next;
      s_axi_arready <= (rd_state_next == CTE_RD_IDLE);
      s_axi_rvalid  <= (rd_state_next == CTE_RD_RESP);
      if (rd_take) begin
        // upper bits of every register read as zero
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? CTE_RESP_OKAY : CTE_RESP_SLVERR;
      end
    end
  end
endmodule // cte_top
`default_nettype wire

//--- test/cte_chk.sv
// cte_chk.sv: port-level assertions for the edge-control block
// assumes: bound to cte_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module cte_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // block outputs
  input wire logic [1:0]  current_range,
  input wire logic [5:0]  current_trim,
  input wire logic        cur_src_en,
  input wire logic        chan1_event_flag,
  input wire logic        chan2_event_flag
);
  // ==========================================================
  // common clocking; reset masks every check
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // configuration copies move only around a write response
  range_copy_a: assert property ($changed(current_range) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("range moved");
  trim_copy_a: assert property ($changed(current_trim) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("trim moved");
  // sticky flags drop only after software wrote them
  flag1_sticky_a: assert property ($fell(chan1_event_flag) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("flag1 fell");
  flag2_sticky_a: assert property ($fell(chan2_event_flag) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("flag2 fell");

  // ==========================================================
  // current source spans channel 1 event to channel 2 event
  src_on_a: assert property ($rose(cur_src_en) |=>
    $rose(chan1_event_flag)) else $error("source on without flag1");
  src_off_a: assert property ($fell(cur_src_en) |=>
    $rose(chan2_event_flag)) else $error("source off without flag2");

  // ==========================================================
  // bus answer timing as handed over
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");

  // ==========================================================
  // main scenarios reached
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_on: cover property ($rose(cur_src_en));
  c_f2: cover property ($rose(chan2_event_flag));
endmodule // cte_chk

bind cte_top cte_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .current_range, .current_trim,
  .cur_src_en, .chan1_event_flag, .chan2_event_flag);
`default_nettype wire

//--- test/cte_src_model.sv
// cte_src_model.sv: edge pins and compare triggers seen by the block
// assumes: lvl indexed by selector code (3 pin one .. 0 compare two)
`timescale 1ns/1ps
`default_nettype none
module cte_src_model #(
  parameter int PIN_DLY = 11
) (
  // clock and requested levels
  input  wire logic       aclk,
  input  wire logic [3:0] lvl,
  // driven sources
  output var  logic       edge_pin_one,
  output var  logic       edge_pin_two,
  output var  logic       cmp_trig_one,
  output var  logic       cmp_trig_two
);
  // pins wander in off the clock grid, slower than one cycle
  initial begin
    {edge_pin_one, edge_pin_two, cmp_trig_one, cmp_trig_two} = 4'h1;
  end
  always @(lvl) begin
    edge_pin_one <= #PIN_DLY lvl[3];
    edge_pin_two <= #PIN_DLY lvl[2];
  end
  // compare triggers come from logic on the same clock
  always @(posedge aclk) begin
    cmp_trig_one <= lvl[1];
    cmp_trig_two <= lvl[0];
  end
endmodule // cte_src_model
`default_nettype wire

//--- test/cte_top_tb_top.sv
// cte_top_tb_top.sv: self-checking bench for the edge-control block
// assumes: cte_top, cte_chk and cte_src_model compiled before
`timescale 1ns/1ps
`default_nettype none
module cte_top_tb_top;
  import cte_pkg::*;
  // ==========================================================
  // signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, lvl;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        edge_pin_one, edge_pin_two, cmp_trig_one, cmp_trig_two;
  logic        cur_src_en, chan1_event_flag, chan2_event_flag;
  logic [1:0]  current_range;
  logic [5:0]  current_trim;
  cte_resp_t   s_axi_bresp, s_axi_rresp;
  logic [31:0] rd_val;
  int          miscompares, n_checks;

  cte_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .edge_pin_one,
    .edge_pin_two, .cmp_trig_one, .cmp_trig_two, .current_range,
    .current_trim, .cur_src_en, .chan1_event_flag, .chan2_event_flag);
  cte_src_model u_src (.aclk, .lvl, .edge_pin_one, .edge_pin_two,
    .cmp_trig_one, .cmp_trig_two);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ==========================================================
  // report helpers
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // bus master: each channel released at its own handshake edge
  task automatic wr(input logic [7:0] a, d, input cte_resp_t er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      miscompares++;
      end_sim();
    end
    chk("bresp", er, s_axi_bresp);
  endtask
  // rready comes one cycle late so the slave must hold its answer
  task automatic rd(input logic [7:0] a, input cte_resp_t er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    rd_val = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      miscompares++;
      end_sim();
    end
    chk("rresp", er, s_axi_rresp);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_map;
    rd(8'h00, CTE_RESP_OKAY);
    chk("cur reset", 32'h0, rd_val);
    rd(8'h04, CTE_RESP_OKAY);
    chk("edge low reset", 32'h0, rd_val);
    rd(8'h08, CTE_RESP_OKAY);
    chk("edge high reset", 32'h0, rd_val);
    rd(8'h0C, CTE_RESP_SLVERR);
    chk("unmapped data", 32'h0, rd_val);
    wr(8'h0C, 8'hFF, CTE_RESP_SLVERR);
  endtask
  // trim codes 20h, 1Fh and 0 and range codes 0, 1 and 3 land on the analog controls
  task automatic t_current;
    logic [7:0] tv [3] = '{8'h80, 8'h7D, 8'h03};
    foreach (tv[i]) begin
      wr(8'h00, tv[i], CTE_RESP_OKAY);
      rd(8'h00, CTE_RESP_OKAY);
      chk("cur readback", {24'h0, tv[i]}, rd_val);
      chk("range", {30'h0, tv[i][1:0]}, {30'h0, current_range});
      chk("trim", {26'h0, tv[i][7:2]}, {26'h0, current_trim});
    end
  endtask
  // every selector code on one channel, other sources held active
  task automatic t_select(input int ch);
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = (ch == 1) ? {3'h0, 1'b1, c[1:0], 2'h0} : {1'b1, c[1:0], 5'h0};
      lvl <= 4'hF ^ (4'h1 << c);
      repeat (6) @(posedge aclk);
      // old config may still match at the first write; set wins
      wr(8'h04, v, CTE_RESP_OKAY);
      wr(8'h04, v, CTE_RESP_OKAY);
      rd(8'h04, CTE_RESP_OKAY);
      chk("sel field", {24'h0, v[7:2]}, {24'h0, rd_val[7:2]});
      chk("flag quiet", 32'h0, {31'h0, rd_val[ch-1]});
      lvl <= 4'hF;
      repeat (6) @(posedge aclk);
      rd(8'h04, CTE_RESP_OKAY);
      chk("flag set", 32'h1, {31'h0, rd_val[ch-1]});
      chk("flag pin", 32'h1, (ch == 1) ? chan1_event_flag
                                      : chan2_event_flag);
    end
  endtask
  // low-level response, rewrite that matches, clear while matching
  task automatic t_polarity;
    wr(8'h04, 8'h04, CTE_RESP_OKAY);
    lvl <= 4'h2;
    repeat (3) @(posedge aclk);
    rd(8'h04, CTE_RESP_OKAY);
    chk("low pol high in", 32'h0, {31'h0, rd_val[0]});
    lvl <= 4'h0;
    repeat (3) @(posedge aclk);
    rd(8'h04, CTE_RESP_OKAY);
    chk("low pol low in", 32'h1, {31'h0, rd_val[0]});
    wr(8'h04, 8'h14, CTE_RESP_OKAY);
    wr(8'h04, 8'h14, CTE_RESP_OKAY);
    rd(8'h04, CTE_RESP_OKAY);
    chk("cleared", 32'h0, {31'h0, rd_val[0]});
    wr(8'h04, 8'h04, CTE_RESP_OKAY);
    rd(8'h04, CTE_RESP_OKAY);
    chk("rewrite match", 32'h1, {31'h0, rd_val[0]});
    wr(8'h04, 8'h04, CTE_RESP_OKAY);
    rd(8'h04, CTE_RESP_OKAY);
    chk("level holds", 32'h1, {31'h0, rd_val[0]});
  endtask
  // channel 2 refused until channel 1, source spans the pair
  task automatic t_sequence;
    wr(8'h08, 8'hFF, CTE_RESP_OKAY);
    rd(8'h08, CTE_RESP_OKAY);
    chk("seq bit only", 32'h4, rd_val);
    lvl <= 4'h0;
    wr(8'h04, 8'h94, CTE_RESP_OKAY);
    wr(8'h04, 8'h94, CTE_RESP_OKAY);
    lvl <= 4'h1;
    repeat (3) @(posedge aclk);
    rd(8'h04, CTE_RESP_OKAY);
    chk("ch2 refused", 32'h0, {30'h0, rd_val[1:0]});
    lvl <= 4'h2;
    repeat (3) @(posedge aclk);
    rd(8'h04, CTE_RESP_OKAY);
    chk("ch1 first", 32'h1, {30'h0, rd_val[1:0]});
    chk("src on", 32'h1, {31'h0, cur_src_en});
    lvl <= 4'h3;
    repeat (3) @(posedge aclk);
    rd(8'h04, CTE_RESP_OKAY);
    chk("ch2 after", 32'h3, {30'h0, rd_val[1:0]});
    chk("src off", 32'h0, {31'h0, cur_src_en});
    wr(8'h08, 8'h00, CTE_RESP_OKAY);
  endtask

  // ==========================================================
  // main sequence; compare two held high so nothing matches at reset
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    lvl = 4'h1;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_map();
    t_current();
    t_select(1);
    t_select(2);
    t_polarity();
    t_sequence();
    end_sim();
  end
endmodule // cte_top_tb_top
`default_nettype wire
